// ---- design/fpcd_decoder.sv ----
// programmed i/o command decoder, register file and execution control
// assumes an arithmetic engine and a control store on the same clock
`timescale 1ns/1ps
module fpcd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // programmed i/o command and reply
  input fpcd_pkg::fpcd_cmd_t cmd_i,
  output logic cmd_ready,
  output fpcd_pkg::fpcd_rsp_t rsp_o,
  // arithmetic engine
  output fpcd_pkg::fpcd_exec_req_t exec_o,
  input fpcd_pkg::fpcd_exec_rsp_t exec_i,
  // control store
  output fpcd_pkg::fpcd_cs_req_t cs_o,
  input wire logic [63:0] cs_rdata,
  // status view
  output logic [31:0] status_o,
  output logic [4:0] task_id_o,
  output logic cs_mode_o
);
  fpcd_pkg::fpcd_state_t state_q;
  logic ready_q;
  fpcd_pkg::fpcd_rsp_t rsp_q;
  fpcd_pkg::fpcd_exec_req_t exec_q;
  fpcd_pkg::fpcd_cs_req_t cs_q;
  logic [31:0] status_q;
  logic [4:0] tid_q;
  logic cs_mode_q;
  logic [31:0] ir_q;
  logic [31:0] fr_q [fpcd_pkg::FR_DEPTH];
  logic [31:0] tstat_q [fpcd_pkg::TASKS];
  logic [5:0] src_q;
  logic [5:0] dst_q;
  logic [7:0] opc_q;

  // field extraction at fixed positions
  wire [31:0] a = cmd_i.addr;
  wire [1:0] op1x = a[fpcd_pkg::OP1X_LSB +: 2]; // see RULE21
  wire [1:0] op2x = a[fpcd_pkg::OP2X_LSB +: 2];
  wire [1:0] ds = a[fpcd_pkg::DS_LSB +: 2];
  wire [7:0] opc = a[fpcd_pkg::OPC_LSB +: 8];
  wire [5:0] idx1 = {op1x, a[fpcd_pkg::OP1_LSB +: 4]}; // see RULE10
  wire [5:0] idx2 = {op2x, a[fpcd_pkg::OP2_LSB +: 4]}; // see RULE10
  wire x_bit = ds[1];
  wire acc = cmd_i.valid & ready_q;
  wire exc_pend = status_q[fpcd_pkg::ST_TX_BIT];

  // dispatch on opcode qualified by data-select
  wire priv_ds = (ds == fpcd_pkg::DS_PRIV); // see RULE21
  wire is_cs = priv_ds & (op1x == fpcd_pkg::EXT_NONE) & (op2x == fpcd_pkg::EXT_CS);
  wire exts0 = (op1x == fpcd_pkg::EXT_NONE) & (op2x == fpcd_pkg::EXT_NONE);
  wire is_control_store_access_disable = priv_ds & exts0 & (opc == fpcd_pkg::OPC_NO_OPERATION_COMMAND) & !cmd_i.store;
  wire is_no_operation_command = !priv_ds & (opc == fpcd_pkg::OPC_NO_OPERATION_COMMAND) & cmd_i.store; // see RULE19
  wire is_frw = cmd_i.store & (opc == fpcd_pkg::OPC_FR_WRITE) & !priv_ds;
  wire is_stw = cmd_i.store & (opc == fpcd_pkg::OPC_STAT_WRITE) & !priv_ds;
  wire is_rdir = !cmd_i.store & (opc == fpcd_pkg::OPC_IR_READ) & !priv_ds;
  wire is_tsw = cmd_i.store & (opc == fpcd_pkg::OPC_TSW_EXC) & !priv_ds;
  wire is_exec = cmd_i.store & !priv_ds & (opc inside {
    fpcd_pkg::OPC_TRUNC_LW, fpcd_pkg::OPC_ATAN_L, fpcd_pkg::OPC_ATAN2_L,
    fpcd_pkg::OPC_CMPT_S, fpcd_pkg::OPC_CMPT_L, fpcd_pkg::OPC_COS_L,
    fpcd_pkg::OPC_EXP_L, fpcd_pkg::OPC_INT_L, fpcd_pkg::OPC_LOGB_L,
    fpcd_pkg::OPC_LOG10_L, fpcd_pkg::OPC_LN_L, fpcd_pkg::OPC_MOD_L,
    fpcd_pkg::OPC_REM_L, fpcd_pkg::OPC_SCALB_L});

  // immediate goes to R1, the high half when R1 names a pair
  wire imm_ld = acc & x_bit & (is_exec | is_no_operation_command); // see RULE1, RULE11, RULE19
  // long commands take the immediate into the even (high) word of the pair
  wire imm_long = is_exec & (opc != fpcd_pkg::OPC_CMPT_S);
  wire [5:0] imm_idx = imm_long ? {idx1[5:1], 1'b0} : idx1; // see RULE22
  wire frw_ld = acc & is_frw; // see RULE2
  // long operands read even-odd pairs, high word in the even one
  wire [5:0] p1 = {src_q[5:1], 1'b0}; // see RULE22
  wire [5:0] p2 = {dst_q[5:1], 1'b0}; // see RULE22
  wire short_cmp = (opc_q == fpcd_pkg::OPC_CMPT_S);
  wire is_cmp = short_cmp | (opc_q == fpcd_pkg::OPC_CMPT_L);
  wire is_tlw = (opc_q == fpcd_pkg::OPC_TRUNC_LW);
  wire [63:0] opa = short_cmp ? {fr_q[src_q], 32'h0000_0000} : {fr_q[p1], fr_q[p1 + 6'h01]};
  wire [63:0] opb = short_cmp ? {fr_q[dst_q], 32'h0000_0000} : {fr_q[p2], fr_q[p2 + 6'h01]};

  // writeback: compares write nothing, source pair never touched
  wire done = (state_q == fpcd_pkg::ST_EXEC) & exec_i.done;
  wire wb_pair = done & !is_cmp & !is_tlw; // see RULE11, RULE12, RULE13
  wire wb_word = done & is_tlw; // see RULE1

  // status after an operation completes
  wire unord_trap = is_cmp & exec_i.unordered; // see RULE16
  logic [31:0] st_done;
  always_comb begin
    st_done = status_q;
    st_done[fpcd_pkg::ST_CO_BIT] = !exec_i.partial;
    if (is_cmp) begin
      st_done[fpcd_pkg::ST_N_BIT] = exec_i.neg; // see RULE16
      st_done[fpcd_pkg::ST_Z_BIT] = exec_i.zero; // see RULE16
    end
    if (exec_i.partial) begin
      st_done[fpcd_pkg::ST_TX_BIT] = 1'b1; // see RULE17, RULE18
      st_done[fpcd_pkg::ST_TFT_LSB +: 3] = fpcd_pkg::TFT_PARTIAL; // see RULE17, RULE18
    end else if (unord_trap) begin
      st_done[fpcd_pkg::ST_TX_BIT] = 1'b1;
      st_done[fpcd_pkg::ST_TFT_LSB +: 3] = fpcd_pkg::TFT_INVALID;
    end
  end

  // protected bits keep their value on a user write
  wire [31:0] st_user = (status_q & ~fpcd_pkg::ST_USER_MASK) |
                        (cmd_i.imm & fpcd_pkg::ST_USER_MASK); // see RULE3
  wire [4:0] new_tid = cmd_i.imm[4:0]; // see RULE8
  wire tsw_ok = acc & is_tsw & !exc_pend; // see RULE9
  wire cs_ok = acc & is_cs & cs_mode_q; // see RULE5, RULE6

  // next state
  fpcd_pkg::fpcd_state_t state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      fpcd_pkg::ST_IDLE: begin
        if (acc & is_exec) begin
          state_d = fpcd_pkg::ST_READ;
        end else if (cs_ok & !cmd_i.store) begin
          state_d = fpcd_pkg::ST_CSRD;
        end
      end
      fpcd_pkg::ST_READ: state_d = fpcd_pkg::ST_EXEC;
      fpcd_pkg::ST_EXEC: begin
        if (exec_i.done) begin
          state_d = fpcd_pkg::ST_IDLE;
        end
      end
      fpcd_pkg::ST_CSRD: state_d = fpcd_pkg::ST_IDLE;
      default: state_d = fpcd_pkg::ST_IDLE;
    endcase
  end

  // reply in the cycle after acceptance, or in the cycle after ST_CSRD for a control store read
  fpcd_pkg::fpcd_rsp_t rsp_d;
  always_comb begin
    rsp_d = '0;
    if (state_q == fpcd_pkg::ST_CSRD) begin
      rsp_d.valid = 1'b1;
      rsp_d.data = cs_q.lo_sel ? cs_rdata[31:0] : cs_rdata[63:32]; // see RULE5
    end else if (acc & !cs_ok | acc & cs_ok & cmd_i.store) begin
      rsp_d.valid = 1'b1;
      rsp_d.exc = (is_tsw & exc_pend) | (is_cs & !cs_mode_q); // see RULE9
      rsp_d.data = is_rdir ? ir_q : 32'h0000_0000; // see RULE4, RULE7
    end
  end

  // floating register file; all 64 words reachable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < fpcd_pkg::FR_DEPTH; i++) begin
        fr_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (imm_ld) begin
        fr_q[imm_idx] <= cmd_i.imm;
      end
      if (frw_ld) begin
        fr_q[idx2] <= cmd_i.imm;
      end
      if (wb_word) begin
        fr_q[dst_q] <= exec_i.result[31:0];
      end
      if (wb_pair) begin
        fr_q[p2] <= exec_i.result[63:32]; // see RULE14, RULE15, RULE20
        fr_q[p2 + 6'h01] <= exec_i.result[31:0];
      end
    end
  end

  // sequencing, requests and replies
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= fpcd_pkg::ST_IDLE;
      ready_q <= 1'b0;
      rsp_q <= '0;
      exec_q <= '0;
      cs_q <= '0;
      src_q <= 6'h00;
      dst_q <= 6'h00;
      opc_q <= 8'h00;
      ir_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == fpcd_pkg::ST_IDLE);
      rsp_q <= rsp_d;
      exec_q.valid <= (state_q == fpcd_pkg::ST_READ);
      exec_q.opcode <= opc_q;
      exec_q.a <= opa;
      exec_q.b <= opb;
      cs_q.rd <= cs_ok & !cmd_i.store;
      cs_q.wr <= cs_ok & cmd_i.store; // see RULE6
      if (acc & is_cs) begin
        cs_q.addr <= a[fpcd_pkg::CSA_LSB +: 16]; // see RULE5, RULE6
        cs_q.lo_sel <= a[fpcd_pkg::Y_BIT];
        cs_q.wdata <= cmd_i.imm;
      end
      if (acc & is_exec) begin
        src_q <= idx1;
        dst_q <= idx2;
        opc_q <= opc;
        ir_q <= a; // kept for the instruction register read
      end
    end
  end

  // status, task identity and control store mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_q <= fpcd_pkg::ST_RESET;
      tid_q <= 5'h00;
      cs_mode_q <= 1'b1; // loading begins in access mode
      for (int i = 0; i < fpcd_pkg::TASKS; i++) begin
        tstat_q[i] <= fpcd_pkg::ST_RESET;
      end
    end else begin
      if (done) begin
        status_q <= st_done;
      end else if (acc & is_stw) begin
        status_q <= st_user; // see RULE3
        tstat_q[tid_q] <= st_user; // see RULE3
      end else if (tsw_ok) begin
        tstat_q[tid_q] <= status_q;
        tid_q <= new_tid; // see RULE8
        status_q <= tstat_q[new_tid]; // see RULE8
      end
      if (acc & is_control_store_access_disable) begin
        cs_mode_q <= 1'b0; // see RULE4
      end
    end
  end

  assign cmd_ready = ready_q;
  assign rsp_o = rsp_q;
  assign exec_o = exec_q;
  assign cs_o = cs_q;
  assign status_o = status_q;
  assign task_id_o = tid_q;
  assign cs_mode_o = cs_mode_q;
endmodule : fpcd_decoder

// ---- design/fpcd_pkg.sv ----
// constants, field layout and carrier types for the float command decoder
// assumes command addresses numbered with bit 0 as the lsb of the word
//
// Contract
// RULE1: truncate long to word into second register
// RULE2: float register write stores immediate to R2
// RULE3: status write honours user-protected bits
// RULE4: disable command ends control store mode
// RULE5: control store read returns selected half
// RULE6: control store write stores selected half
// RULE7: instruction register read returns failing command
// RULE8: task switch loads id, restores status
// RULE9: pending exception gives exception reply
// RULE10: full 64-word register file is addressable
// RULE11: arc tangents write second pair
// RULE12: cosine and exponential write second pair
// RULE13: logarithms write second pair, source kept
// RULE14: exponent extraction writes second pair
// RULE15: integer part writes second pair
// RULE16: trapping compares set n, z, trap unordered
// RULE17: partial modulo raises type 110 exception
// RULE18: partial remainder raises type 110 exception
// RULE19: no-op may load first register only
// RULE20: scale binary writes second pair
// RULE21: fixed field positions, dispatch on opcode
// RULE22: long operands use even-odd register pairs
package fpcd_pkg;
  // command address field positions (lsb index)
  localparam int OP1X_LSB = 22;
  localparam int OP2X_LSB = 20;
  localparam int DS_LSB = 18;
  localparam int OPC_LSB = 10;
  localparam int OP1_LSB = 6;
  localparam int OP2_LSB = 2;
  localparam int CSA_LSB = 2;
  localparam int Y_BIT = 0;
  localparam int TASK_W = 5;
  localparam int FR_DEPTH = 64;
  localparam int TASKS = 32;
  // qualifier values
  localparam logic [1:0] DS_PRIV = 2'h3;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_CS = 2'h1;
  // opcodes
  localparam logic [7:0] OPC_TRUNC_LW = 8'h2b;
  localparam logic [7:0] OPC_FR_WRITE = 8'h94;
  localparam logic [7:0] OPC_STAT_WRITE = 8'h0f;
  localparam logic [7:0] OPC_NO_OPERATION_COMMAND = 8'h9f;
  localparam logic [7:0] OPC_IR_READ = 8'hbf;
  localparam logic [7:0] OPC_TSW_EXC = 8'h9d;
  localparam logic [7:0] OPC_ATAN_L = 8'hd4;
  localparam logic [7:0] OPC_ATAN2_L = 8'h52;
  localparam logic [7:0] OPC_CMPT_S = 8'h4b;
  localparam logic [7:0] OPC_CMPT_L = 8'h4a;
  localparam logic [7:0] OPC_COS_L = 8'hc2;
  localparam logic [7:0] OPC_EXP_L = 8'hd8;
  localparam logic [7:0] OPC_INT_L = 8'hca;
  localparam logic [7:0] OPC_LOGB_L = 8'h56;
  localparam logic [7:0] OPC_LOG10_L = 8'hde;
  localparam logic [7:0] OPC_LN_L = 8'hdc;
  localparam logic [7:0] OPC_MOD_L = 8'h42;
  localparam logic [7:0] OPC_REM_L = 8'h62;
  localparam logic [7:0] OPC_SCALB_L = 8'h72;
  // status register layout
  localparam int ST_CO_BIT = 16;
  localparam int ST_TX_BIT = 15;
  localparam int ST_TFT_LSB = 12;
  localparam int ST_N_BIT = 1;
  localparam int ST_Z_BIT = 0;
  localparam logic [2:0] TFT_PARTIAL = 3'h6;
  localparam logic [2:0] TFT_INVALID = 3'h5;
  localparam logic [31:0] ST_USER_MASK = 32'h0000_0fff;
  localparam logic [31:0] ST_RESET = 32'h0001_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_EXEC = 2'b11,
    ST_CSRD = 2'b10
  } fpcd_state_t;

  typedef struct packed {
    logic valid;
    logic store;
    logic [31:0] addr;
    logic [31:0] imm;
  } fpcd_cmd_t;

  typedef struct packed {
    logic valid;
    logic exc;
    logic [31:0] data;
  } fpcd_rsp_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [63:0] a;
    logic [63:0] b;
  } fpcd_exec_req_t;

  typedef struct packed {
    logic done;
    logic partial;
    logic unordered;
    logic neg;
    logic zero;
    logic [63:0] result;
  } fpcd_exec_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic lo_sel;
    logic [15:0] addr;
    logic [31:0] wdata;
  } fpcd_cs_req_t;
endpackage : fpcd_pkg

// ---- test/fpcd_chk.sv ----
// port-level assertions for the float command decoder
// assumes it is bound onto fpcd_decoder, one clock domain
`timescale 1ns/1ps
module fpcd_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input fpcd_pkg::fpcd_cmd_t cmd_i,
  input wire logic cmd_ready,
  input fpcd_pkg::fpcd_rsp_t rsp_o,
  input fpcd_pkg::fpcd_exec_req_t exec_o,
  input fpcd_pkg::fpcd_exec_rsp_t exec_i,
  input fpcd_pkg::fpcd_cs_req_t cs_o,
  input wire logic [63:0] cs_rdata,
  input wire logic [31:0] status_o,
  input wire logic [4:0] task_id_o,
  input wire logic cs_mode_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // host-side decode of the taken command
  wire logic tk = cmd_i.valid && cmd_ready;
  wire logic [7:0] opc = cmd_i.addr[17:10];
  wire logic csc = tk && cmd_i.addr[21:18] == 4'h7;
  wire logic tsw = tk && cmd_i.store && cmd_i.addr[19:18] == 2'h0 && opc == 8'h9d;
  wire logic ex = tk && cmd_i.store && cmd_i.addr[19:18] != 2'h3 && opc inside {8'h2b, 8'hd4,
    8'h52, 8'hc2, 8'hd8, 8'hca, 8'h56, 8'hde, 8'hdc, 8'h42, 8'h62, 8'h72, 8'h4a, 8'h4b};
  a_exec_launch: assert property (ex |-> ##2 exec_o.valid && exec_o.opcode == $past(opc, 2))
    else $error("exec launch");
  a_cs_write: assert property (csc && cmd_i.store && cs_mode_o |=> cs_o.wr &&
    cs_o.addr == $past(cmd_i.addr[17:2]) && cs_o.lo_sel == $past(cmd_i.addr[0])
    && cs_o.wdata == $past(cmd_i.imm)) else $error("cs write");
  a_cs_read: assert property (csc && !cmd_i.store && cs_mode_o |=> cs_o.rd &&
    cs_o.addr == $past(cmd_i.addr[17:2]) ##1 rsp_o.valid && rsp_o.data ==
    ($past(cs_o.lo_sel) ? $past(cs_rdata[31:0]) : $past(cs_rdata[63:32])))
    else $error("cs read");
  a_cs_refuse: assert property (csc && !cs_mode_o |=> rsp_o.exc && !cs_o.rd && !cs_o.wr)
    else $error("cs refuse");
  a_cs_disable: assert property (tk && !cmd_i.store && cmd_i.addr[21:18] == 4'h3
    && opc == 8'h9f |=> !cs_mode_o) else $error("cs disable");
  a_task_load: assert property (tsw && !status_o[15] |=>
    task_id_o == $past(cmd_i.imm[4:0]) && !rsp_o.exc) else $error("task load");
  a_task_refuse: assert property (tsw && status_o[15] |=> rsp_o.exc && $stable(task_id_o))
    else $error("task refuse");
  a_partial_status: assert property (exec_i.done && exec_i.partial |=> !status_o[16]
    && status_o[15] && status_o[14:12] == 3'h6) else $error("partial status");
  a_ready_back: assert property (exec_i.done |-> ##[1:2] cmd_ready)
    else $error("ready back");
endmodule : fpcd_chk
bind fpcd_decoder fpcd_chk u_chk (.clk, .nrst, .cmd_i, .cmd_ready, .rsp_o, .exec_o, .exec_i,
  .cs_o, .cs_rdata, .status_o, .task_id_o, .cs_mode_o);

// ---- test/fpcd_decoder_tb.sv ----
// self-checking bench for the float command decoder
// assumes fpcd_partner on the far side and the bound checker
`timescale 1ns/1ps
module fpcd_decoder_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  fpcd_pkg::fpcd_cmd_t cmd_i = '0;
  fpcd_pkg::fpcd_rsp_t rsp_o, r;
  fpcd_pkg::fpcd_exec_req_t exec_o;
  fpcd_pkg::fpcd_exec_rsp_t exec_i;
  fpcd_pkg::fpcd_cs_req_t cs_o;
  logic [63:0] cs_rdata;
  logic [31:0] status_o, last, fr [64];
  logic [4:0] task_id_o;
  logic [3:0] dly = 4'h1;
  logic cmd_ready, cs_mode_o, part = 1'b0, unord = 1'b0, neg = 1'b0, zero = 1'b0;
  int num_errors = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  fpcd_decoder uut (.clk, .nrst, .cmd_i, .cmd_ready, .rsp_o, .exec_o, .exec_i, .cs_o,
    .cs_rdata, .status_o, .task_id_o, .cs_mode_o);
  fpcd_partner u_far (.clk, .nrst, .req(exec_o), .rsp(exec_i), .cs_req(cs_o), .cs_rdata,
    .dly, .part, .unord, .neg, .zero);
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic check(input string n, input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  function automatic logic [31:0] mk(input logic [5:0] r1, r2, input logic [1:0] ds,
    input logic [7:0] op);
    return {8'h00, r1[5:4], r2[5:4], ds, op, r1[3:0], r2[3:0], 2'h0};
  endfunction : mk
  // one command held until taken, reply sampled lat cycles later
  task automatic send(input logic st, input logic [31:0] a, d, input int lat);
    @(posedge clk);
    cmd_i <= {1'b1, st, a, d};
    @(negedge clk);
    for (int i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    cmd_i.valid <= 1'b0;
    repeat (lat) @(negedge clk);
    r = rsp_o;
    check("rsp_valid", r.valid, 1'b1);
  endtask : send
  // exec command: operands, write-back and status against the shadow file
  task automatic op(input logic [7:0] opc, input logic [5:0] r1, r2, input logic x,
    input logic [31:0] imm);
    logic [5:0] p1, p2;
    logic [63:0] a, b, res;
    int k;
    p1 = {r1[5:1], 1'b0};
    p2 = {r2[5:1], 1'b0};
    k = opc == 8'h2b ? 1 : opc == 8'h4a ? 2 : opc == 8'h4b ? 3 : 0;
    if (x) fr[k == 3 ? r1 : p1] = imm;
    a = k == 3 ? {fr[r1], 32'h0} : {fr[p1], fr[p1 + 1]};
    b = k == 3 ? {fr[r2], 32'h0} : {fr[p2], fr[p2 + 1]};
    last = mk(r1, r2, {x, 1'b0}, opc);
    send(1'b1, last, imm, 1);
    for (int i = 0; i < 8 && exec_o.valid !== 1'b1; i++) @(negedge clk);
    check("exec_op", exec_o.opcode, opc);
    check("exec_a", exec_o.a, a);
    check("exec_b", exec_o.b, b);
    res = a + b;
    for (int i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clk);
    check("ready", cmd_ready, 1'b1);
    if (k == 0) {fr[p2], fr[p2 + 1]} = res;
    if (k == 1) fr[r2] = res[31:0];
    if (k > 1 && !unord) check("nz", status_o[1:0], {neg, zero});
    if (unord) check("unord", status_o[15:12], 4'hd);
    if (part) check("partial", status_o[16:12], 5'h0e);
  endtask : op
  task automatic t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    foreach (fr[i]) fr[i] = '0;
    repeat (2) @(negedge clk);
    check("status", status_o, 32'h0001_0000);
    check("cs_mode", {task_id_o, cs_mode_o}, 6'h01);
  endtask : t_reset
  task automatic t_cs;
    for (int y = 0; y < 2; y++) send(1'b1, {14'h0007, 16'ha5c3, 1'b0, y[0]}, 32'h5678 + y, 1);
    for (int y = 0; y < 2; y++) begin
      send(1'b0, {14'h0007, 16'ha5c3, 1'b0, y[0]}, 32'h0, 2);
      check("cs_read", r.data, 32'h5678 + y);
    end
    send(1'b0, mk(6'h0, 6'h0, 2'h3, 8'h9f), 32'h0, 1);
    check("cs_mode", cs_mode_o, 1'b0);
    for (int s = 0; s < 2; s++) begin
      send(s[0], {14'h0007, 16'ha5c3, 2'h0}, 32'h0, 1);
      check("cs_refuse", r.exc, 1'b1);
    end
  endtask : t_cs
  task automatic t_task;
    send(1'b1, mk(6'h0e, 6'h0e, 2'h1, 8'h0f), 32'hffff_f5a5, 1);
    check("status", status_o, 32'h0001_05a5);
    send(1'b1, mk(6'h0e, 6'h0e, 2'h0, 8'h9d), 32'hffff_ff13, 1);
    check("task", {task_id_o, status_o}, {5'h13, 32'h0001_0000});
    send(1'b1, mk(6'h0e, 6'h0e, 2'h0, 8'h9d), 32'hffff_ffe0, 1);
    check("task", {task_id_o, status_o}, {5'h00, 32'h0001_05a5});
  endtask : t_task
  task automatic t_ops;
    logic [5:0] rl [4] = '{6'h3e, 6'h3f, 6'h02, 6'h03};
    logic [7:0] ol [14] = '{8'h2b, 8'hd4, 8'h52, 8'hc2, 8'hd8, 8'hca, 8'h56, 8'hde, 8'hdc,
      8'h42, 8'h62, 8'h72, 8'h4a, 8'h4b};
    for (int i = 0; i < 4; i++) begin
      send(1'b1, mk(6'h0, rl[i], 2'h0, 8'h94), 32'h9000_0001 + i, 1);
      fr[rl[i]] = 32'h9000_0001 + i;
    end
    send(1'b1, mk(6'h20, 6'h0, 2'h2, 8'h9f), 32'h1111_2222, 1);
    fr[6'h20] = 32'h1111_2222;
    for (int i = 0; i < 14; i++) begin
      {neg, zero, dly} = {i[0], i[1], i[3:0] + 4'h1};
      op(ol[i], i[1] ? 6'h21 : 6'h3e, 6'h02 + i[2], i[0], 32'hc0de_0000 + i);
    end
    send(1'b0, mk(6'h0, 6'h0, 2'h0, 8'hbf), 32'h0, 1);
    check("ir", r.data, last);
  endtask : t_ops
  task automatic t_trap;
    unord = 1'b1;
    op(8'h4a, 6'h3e, 6'h02, 1'b0, 32'h0);
    send(1'b1, mk(6'h0e, 6'h0e, 2'h0, 8'h9d), 32'h5, 1);
    check("tsw_exc", {r.exc, task_id_o}, 6'h20);
    {unord, part} = 2'b01;
    for (int i = 0; i < 2; i++) begin
      t_reset();
      op(i[0] ? 8'h62 : 8'h42, 6'h3e, 6'h02, 1'b1, 32'h4000_0000);
    end
  endtask : t_trap
  initial begin
    t_reset();
    t_cs();
    t_task();
    t_ops();
    t_trap();
    summarize();
  end
  // hang guard well beyond the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end
endmodule : fpcd_decoder_tb

// ---- test/fpcd_partner.sv ----
// arithmetic engine and control store standing beside the decoder
// assumes the bench sets delay and result flags before each operation
`timescale 1ns/1ps
module fpcd_partner (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // engine side
  input fpcd_pkg::fpcd_exec_req_t req,
  output fpcd_pkg::fpcd_exec_rsp_t rsp,
  // control store side
  input fpcd_pkg::fpcd_cs_req_t cs_req,
  output logic [63:0] cs_rdata,
  // behaviour controls
  input wire logic [3:0] dly,
  input wire logic part,
  input wire logic unord,
  input wire logic neg,
  input wire logic zero
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [63:0] sum_q;
  logic [63:0] mem [256];
  wire logic done = busy_q && cnt_q == 4'h0;
  // engine: result is a+b after dly cycles, partial on demand
  always @(posedge clk) begin
    if (!nrst) busy_q <= 1'b0;
    else if (req.valid) {busy_q, cnt_q, sum_q} <= {1'b1, dly, req.a + req.b};
    else if (done) busy_q <= 1'b0;
    else if (busy_q) cnt_q <= cnt_q - 4'h1;
  end
  // qualifiers flip outside done so stale values never look right
  assign rsp = done ? {1'b1, part, unord, neg, zero, sum_q}
    : {1'b0, ~part, ~unord, ~neg, ~zero, ~sum_q};
  // control store: y selects upper or lower half
  always @(posedge clk) begin
    if (cs_req.wr && cs_req.lo_sel) mem[cs_req.addr[7:0]][31:0] <= cs_req.wdata;
    if (cs_req.wr && !cs_req.lo_sel) mem[cs_req.addr[7:0]][63:32] <= cs_req.wdata;
  end
  assign cs_rdata = cs_req.rd ? mem[cs_req.addr[7:0]] : ~mem[cs_req.addr[7:0]];
endmodule : fpcd_partner
